// ### clock_ctrl_pkg.sv
// Purpose: Shared constants and types of the clock generation controller
// Assumes: 32-bit classic Wishbone register port, byte offsets on word boundaries
// Notes: Source indices double as the system clock select codes
`default_nettype none

package clock_ctrl_pkg;

	// Clock source indices, also the select codes of the system clock mux
	localparam int NUM_SRC = 6;
	localparam logic [2:0] SRC_HS_XTAL = 3'h0;
	localparam logic [2:0] SRC_LS_XTAL = 3'h1;
	localparam logic [2:0] SRC_PLL = 3'h2;
	localparam logic [2:0] SRC_RC10K = 3'h3;
	localparam logic [2:0] SRC_RC22 = 3'h4;
	localparam logic [2:0] SRC_RC48 = 3'h5;
	localparam logic [2:0] TICK_SEL_MAX = 3'h4;

	// Register byte offsets
	localparam logic [7:0] OFF_POWER_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PLL_CTRL = 8'h08;
	localparam logic [7:0] OFF_CLK_SEL0 = 8'h0c;
	localparam logic [7:0] OFF_FAIL_CTRL = 8'h10;
	localparam logic [7:0] OFF_FAIL_STATUS = 8'h14;
	localparam logic [7:0] OFF_CLK_OUT_CTRL = 8'h18;
	localparam logic [7:0] OFF_TICK_CTRL = 8'h1c;

	// Field positions
	localparam int PWR_HS_EN_BIT = 0;
	localparam int PWR_LS_EN_BIT = 1;
	localparam int PWR_RC22_EN_BIT = 2;
	localparam int PWR_RC10K_EN_BIT = 3;
	localparam int PWR_POWERDOWN_BIT = 7;
	localparam int PWR_RC48_EN_BIT = 13;
	localparam int STAT_CUR_SRC_LSB = 8;
	localparam int PLL_POWER_DOWN_BIT = 16;
	localparam int PLL_SRC_BIT = 19;
	localparam int PLL_STAB_SEL_BIT = 23;
	localparam int SEL0_SYS_LSB = 0;
	localparam int SEL0_TICK_LSB = 3;
	localparam int FAIL_HS_DET_BIT = 4;
	localparam int FAIL_HS_IRQ_BIT = 5;
	localparam int FAIL_LS_DET_BIT = 12;
	localparam int FAIL_HS_FLAG_BIT = 0;
	localparam int CLOCK_OUT_PIN_SEL_LSB = 0;
	localparam int CLOCK_OUT_PIN_EN_BIT = 4;
	localparam int CLOCK_OUT_PIN_BYPASS_BIT = 5;
	localparam int TICK_CPU_BIT = 2;

	// Reset values
	localparam logic [31:0] POWER_CTRL_RST = 32'h0000_0004;
	localparam logic [31:0] PLL_CTRL_RST = 32'h0081_0000;
	localparam logic [31:0] CLK_SEL0_RST = 32'h0000_0004;

	// Stability counts, in cycles of the source being counted
	localparam int STABLE_W = 14;
	localparam logic [13:0] STABLE_HS = 14'h1000;
	localparam logic [13:0] STABLE_RC48 = 14'h0200;
	localparam logic [13:0] STABLE_RC22 = 14'h0100;
	localparam logic [13:0] STABLE_LOW = 14'h0001;
	localparam logic [13:0] STABLE_PLL_SHORT = 14'h1800;
	localparam logic [13:0] STABLE_PLL_LONG = 14'h3000;

	localparam int DIV_STAGES = 16;

	typedef enum logic {PWR_RUN = 1'b0, PWR_SLEEP = 1'b1} power_state_t;
	typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_DRAIN = 2'b01, SW_ARM = 2'b11} switch_state_t;

endpackage

`default_nettype wire

// ### stable_counter.sv
// Purpose: Stability counter of one clock source
// Assumes: edge_i is a one-cycle pulse per rising edge of the source
// Notes: Clearing run_i restarts the full interval
`timescale 1ns/1ps
`default_nettype none

module stable_counter #(
	parameter int WIDTH = 14
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic edge_i,
	input wire logic [WIDTH-1:0] target_i,
	output logic stable_o
);

	logic [WIDTH-1:0] count;

	// Count source edges while enabled, flag once the target is reached
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			count <= '0;
			stable_o <= 1'b0;
		end
		else if (!run_i)
		begin
			count <= '0;
			stable_o <= 1'b0;
		end
		else if (count >= target_i)
			stable_o <= 1'b1;
		else if (edge_i)
			count <= count + 1'b1;
	end

endmodule // stable_counter

`default_nettype wire

// ### clock_out_divider.sv
// Purpose: Power-of-two clock output divider with bypass
// Assumes: src_i is a level sampled on the core clock
// Notes: Chain of toggle stages built as a ripple-free counter
`timescale 1ns/1ps
`default_nettype none

module clock_out_divider #(
	parameter int STAGES = 16
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic src_i,
	input wire logic enable_i,
	input wire logic bypass_i,
	input wire logic [3:0] select_i,
	output logic clk_out_o
);

	logic src_prev;
	logic running;
	logic [STAGES-1:0] chain;

	// Rising edges of the source advance the chain
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			src_prev <= 1'b0;
		else
			src_prev <= src_i;
	end

	// Stop only once the chosen stage is low, so no short high pulse
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			running <= 1'b0;
		else if (enable_i)
			running <= 1'b1;
		else if (!chain[select_i])
			running <= 1'b0;
	end

	// Bit k toggles at a 2^(k+1) division of the source
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			chain <= '0;
		else if (!running)
			chain <= '0;
		else if (src_i && !src_prev)
			chain <= chain + 1'b1;
	end

	// Pin level: direct source in bypass, else the selected stage
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			clk_out_o <= 1'b0;
		else if (bypass_i)
			clk_out_o <= enable_i & src_i;
		else
			clk_out_o <= running & chain[select_i];
	end

endmodule // clock_out_divider

`default_nettype wire

// ### clock_generation_control.sv
// Purpose: Chip clock controller: source enables, stability, clock muxes, power-down, fail detect
// Assumes: Oscillator clocks arrive as pins sampled by the 40 MHz core clock
// Notes: Sources faster than half the core clock alias; their edge counts are approximate
// Function
// - Power-down needs enable bit plus wait-for-interrupt
// - Stay powered down until wake-up interrupt
// - Power-down stops high-speed crystal and fast RCs
// - Enable starts counter; flag at per-source count
// - Stable flags at status bits zero to five
// - PLL count 6144 or 12288, select defaults one
// - Use a source only once its flag is set
// - Disabling a source clears its stable flag
// - Power-down clears flags; recount after wake-up (code keeps the LS crystal and RC10K flags)
// - PLL input is crystal or 22 MHz RC
// - Three-bit field selects system clock source
// - Fail detectors force their backup RC on
// - Crystal stop moves system clock to RC
// - Crystal stop sets flag; optional interrupt
// - Tick clock: CPU clock or selected external
// - Low-speed oscillators keep running in power-down
// - Sixteen divide-by-two stages, one selected
// - Output frequency is input over 2^(N+1)
// - Enable starts; disable stops at low level
// - Bypass bit sends source straight out
`timescale 1ns/1ps
`default_nettype none

module clock_generation_control #(
	parameter int FAIL_WINDOW = 64
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [5:0] osc_clk_i,
	input wire logic wait_for_interrupt_instr_i,
	input wire logic wakeup_irq_i,
	output logic [5:0] osc_enable_o,
	output logic pll_src_sel_o,
	output logic sys_clk_o,
	output logic tick_clk_o,
	output logic clock_out_pin_o,
	output logic powerdown_o,
	output logic fail_irq_o
);

	// Software fields
	logic hs_crystal_enable;
	logic ls_crystal_enable;
	logic rc22_enable;
	logic rc10k_enable;
	logic rc48_enable;
	logic powerdown_enable;
	logic pll_power_down;
	logic pll_stability_select;
	logic [2:0] system_clock_select;
	logic [2:0] tick_clock_select;
	logic hs_detect_enable;
	logic ls_detect_enable;
	logic hs_crystal_fail_irq_enable;
	logic hs_crystal_fail_flag;
	logic [3:0] output_divider_select;
	logic clock_out_enable;
	logic divider_bypass;
	logic tick_cpu_clock;

	// Internal state
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [5:0] sync3;
	logic [5:0] osc_level;
	logic [5:0] osc_rise;
	logic [5:0] stable;
	logic [5:0] count_edge;
	logic [5:0] next_osc_enable;
	logic [13:0] stable_target [6];
	clock_ctrl_pkg::power_state_t power_state;
	clock_ctrl_pkg::power_state_t next_power_state;
	clock_ctrl_pkg::switch_state_t switch_state;
	logic [2:0] cur_src;
	logic [15:0] hs_gap;
	logic hs_stop;
	logic sel_valid;
	logic [31:0] rd_value;
	logic [31:0] wmask;
	logic [31:0] wr_merged;
	logic wr_fire;

	// Three-stage sampling of each oscillator pin; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < clock_ctrl_pkg::NUM_SRC; gi++)
		begin : g_osc
			always_ff @(posedge core_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					osc_level[gi] <= 1'b0;
					osc_rise[gi] <= 1'b0;
				end
				else
				begin
					sync1[gi] <= osc_clk_i[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						osc_level[gi] <= sync2[gi];
					osc_rise[gi] <= (sync2[gi] == sync3[gi]) & sync2[gi] & ~osc_level[gi];
				end
			end

			// PLL counts edges of its own input clock
			if (gi == int'(clock_ctrl_pkg::SRC_PLL))
			begin : g_pll_edge
				assign count_edge[gi] = pll_src_sel_o ? osc_rise[clock_ctrl_pkg::SRC_RC22]
					: osc_rise[clock_ctrl_pkg::SRC_HS_XTAL];
			end
			else
			begin : g_own_edge
				assign count_edge[gi] = osc_rise[gi];
			end

			stable_counter #(
				.WIDTH(clock_ctrl_pkg::STABLE_W)
			) u_stable (
				.core_clk_i(core_clk_i),
				.rst_i(rst_i),
				.run_i(osc_enable_o[gi]),
				.edge_i(count_edge[gi]),
				.target_i(stable_target[gi]),
				.stable_o(stable[gi])
			);
		end
	endgenerate

	// Per-source stability targets
	always_comb
	begin
		stable_target[clock_ctrl_pkg::SRC_HS_XTAL] = clock_ctrl_pkg::STABLE_HS;
		stable_target[clock_ctrl_pkg::SRC_LS_XTAL] = clock_ctrl_pkg::STABLE_LOW;
		stable_target[clock_ctrl_pkg::SRC_PLL] = pll_stability_select ? clock_ctrl_pkg::STABLE_PLL_LONG
			: clock_ctrl_pkg::STABLE_PLL_SHORT;
		stable_target[clock_ctrl_pkg::SRC_RC10K] = clock_ctrl_pkg::STABLE_LOW;
		stable_target[clock_ctrl_pkg::SRC_RC22] = clock_ctrl_pkg::STABLE_RC22;
		stable_target[clock_ctrl_pkg::SRC_RC48] = clock_ctrl_pkg::STABLE_RC48;
	end

	// Oscillator enables; dropping one in power-down also clears its flag and counter
	always_comb
	begin
		next_osc_enable[clock_ctrl_pkg::SRC_HS_XTAL] = hs_crystal_enable & (next_power_state == clock_ctrl_pkg::PWR_RUN);
		next_osc_enable[clock_ctrl_pkg::SRC_LS_XTAL] = ls_crystal_enable;
		next_osc_enable[clock_ctrl_pkg::SRC_PLL] = ~pll_power_down & (next_power_state == clock_ctrl_pkg::PWR_RUN);
		next_osc_enable[clock_ctrl_pkg::SRC_RC10K] = rc10k_enable | ls_detect_enable;
		next_osc_enable[clock_ctrl_pkg::SRC_RC22] = (rc22_enable | hs_detect_enable)
			& (next_power_state == clock_ctrl_pkg::PWR_RUN);
		next_osc_enable[clock_ctrl_pkg::SRC_RC48] = rc48_enable & (next_power_state == clock_ctrl_pkg::PWR_RUN);
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			osc_enable_o <= 6'h00;
		else
			osc_enable_o <= next_osc_enable;
	end

	// Power-down entry needs both the enable bit and the wait instruction
	always_comb
	begin
		next_power_state = power_state;
		case (power_state)
			clock_ctrl_pkg::PWR_RUN:
				if (powerdown_enable && wait_for_interrupt_instr_i)
					next_power_state = clock_ctrl_pkg::PWR_SLEEP;
			clock_ctrl_pkg::PWR_SLEEP:
				if (wakeup_irq_i)
					next_power_state = clock_ctrl_pkg::PWR_RUN;
			default:
				next_power_state = clock_ctrl_pkg::PWR_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			power_state <= clock_ctrl_pkg::PWR_RUN;
			powerdown_o <= 1'b0;
		end
		else
		begin
			power_state <= next_power_state;
			powerdown_o <= (next_power_state == clock_ctrl_pkg::PWR_SLEEP);
		end
	end

	// Crystal stop: enabled and stable crystal shows no edge for a whole window
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			hs_gap <= 16'h0000;
		else if (!osc_enable_o[clock_ctrl_pkg::SRC_HS_XTAL] || !stable[clock_ctrl_pkg::SRC_HS_XTAL]
			|| osc_rise[clock_ctrl_pkg::SRC_HS_XTAL])
			hs_gap <= 16'h0000;
		else if (hs_gap != 16'(FAIL_WINDOW))
			hs_gap <= hs_gap + 16'h0001;
	end

	assign hs_stop = hs_detect_enable && (hs_gap == 16'(FAIL_WINDOW - 1))
		&& !osc_rise[clock_ctrl_pkg::SRC_HS_XTAL];

	// Bus handshake: answer one cycle after the request, drop ack the next cycle
	assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wr_merged = (rd_value & ~wmask) | (wb_dat_i & wmask);

	// Read-back; unmapped offsets read zero and are still acknowledged
	always_comb
	begin
		rd_value = 32'h0000_0000;
		if (wb_adr_i == clock_ctrl_pkg::OFF_POWER_CTRL)
		begin
			rd_value[clock_ctrl_pkg::PWR_HS_EN_BIT] = hs_crystal_enable;
			rd_value[clock_ctrl_pkg::PWR_LS_EN_BIT] = ls_crystal_enable;
			rd_value[clock_ctrl_pkg::PWR_RC22_EN_BIT] = rc22_enable;
			rd_value[clock_ctrl_pkg::PWR_RC10K_EN_BIT] = rc10k_enable;
			rd_value[clock_ctrl_pkg::PWR_POWERDOWN_BIT] = powerdown_enable;
			rd_value[clock_ctrl_pkg::PWR_RC48_EN_BIT] = rc48_enable;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_STATUS)
		begin
			rd_value[5:0] = stable;
			rd_value[clock_ctrl_pkg::STAT_CUR_SRC_LSB +: 3] = cur_src;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_PLL_CTRL)
		begin
			rd_value[clock_ctrl_pkg::PLL_POWER_DOWN_BIT] = pll_power_down;
			rd_value[clock_ctrl_pkg::PLL_SRC_BIT] = pll_src_sel_o;
			rd_value[clock_ctrl_pkg::PLL_STAB_SEL_BIT] = pll_stability_select;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_CLK_SEL0)
		begin
			rd_value[clock_ctrl_pkg::SEL0_SYS_LSB +: 3] = system_clock_select;
			rd_value[clock_ctrl_pkg::SEL0_TICK_LSB +: 3] = tick_clock_select;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_FAIL_CTRL)
		begin
			rd_value[clock_ctrl_pkg::FAIL_HS_DET_BIT] = hs_detect_enable;
			rd_value[clock_ctrl_pkg::FAIL_HS_IRQ_BIT] = hs_crystal_fail_irq_enable;
			rd_value[clock_ctrl_pkg::FAIL_LS_DET_BIT] = ls_detect_enable;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_FAIL_STATUS)
			rd_value[clock_ctrl_pkg::FAIL_HS_FLAG_BIT] = hs_crystal_fail_flag;
		else if (wb_adr_i == clock_ctrl_pkg::OFF_CLK_OUT_CTRL)
		begin
			rd_value[clock_ctrl_pkg::CLOCK_OUT_PIN_SEL_LSB +: 4] = output_divider_select;
			rd_value[clock_ctrl_pkg::CLOCK_OUT_PIN_EN_BIT] = clock_out_enable;
			rd_value[clock_ctrl_pkg::CLOCK_OUT_PIN_BYPASS_BIT] = divider_bypass;
		end
		else if (wb_adr_i == clock_ctrl_pkg::OFF_TICK_CTRL)
			rd_value[clock_ctrl_pkg::TICK_CPU_BIT] = tick_cpu_clock;
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= rd_value;
		end
	end

	// Power control fields
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_crystal_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_HS_EN_BIT];
			ls_crystal_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_LS_EN_BIT];
			rc22_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_RC22_EN_BIT];
			rc10k_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_RC10K_EN_BIT];
			powerdown_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_POWERDOWN_BIT];
			rc48_enable <= clock_ctrl_pkg::POWER_CTRL_RST[clock_ctrl_pkg::PWR_RC48_EN_BIT];
		end
		else if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_POWER_CTRL)
		begin
			hs_crystal_enable <= wr_merged[clock_ctrl_pkg::PWR_HS_EN_BIT];
			ls_crystal_enable <= wr_merged[clock_ctrl_pkg::PWR_LS_EN_BIT];
			rc22_enable <= wr_merged[clock_ctrl_pkg::PWR_RC22_EN_BIT];
			rc10k_enable <= wr_merged[clock_ctrl_pkg::PWR_RC10K_EN_BIT];
			powerdown_enable <= wr_merged[clock_ctrl_pkg::PWR_POWERDOWN_BIT];
			rc48_enable <= wr_merged[clock_ctrl_pkg::PWR_RC48_EN_BIT];
		end
	end

	// PLL control fields
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pll_power_down <= clock_ctrl_pkg::PLL_CTRL_RST[clock_ctrl_pkg::PLL_POWER_DOWN_BIT];
			pll_src_sel_o <= clock_ctrl_pkg::PLL_CTRL_RST[clock_ctrl_pkg::PLL_SRC_BIT];
			pll_stability_select <= clock_ctrl_pkg::PLL_CTRL_RST[clock_ctrl_pkg::PLL_STAB_SEL_BIT];
		end
		else if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_PLL_CTRL)
		begin
			pll_power_down <= wr_merged[clock_ctrl_pkg::PLL_POWER_DOWN_BIT];
			pll_src_sel_o <= wr_merged[clock_ctrl_pkg::PLL_SRC_BIT];
			pll_stability_select <= wr_merged[clock_ctrl_pkg::PLL_STAB_SEL_BIT];
		end
	end

	// Clock selects; a crystal stop overrides a software write of the system select in the same cycle
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			system_clock_select <= clock_ctrl_pkg::CLK_SEL0_RST[clock_ctrl_pkg::SEL0_SYS_LSB +: 3];
			tick_clock_select <= clock_ctrl_pkg::CLK_SEL0_RST[clock_ctrl_pkg::SEL0_TICK_LSB +: 3];
		end
		else
		begin
			if (hs_stop && (system_clock_select == clock_ctrl_pkg::SRC_HS_XTAL
				|| (system_clock_select == clock_ctrl_pkg::SRC_PLL && !pll_src_sel_o)))
				system_clock_select <= clock_ctrl_pkg::SRC_RC22;
			else if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_CLK_SEL0)
				system_clock_select <= wr_merged[clock_ctrl_pkg::SEL0_SYS_LSB +: 3];
			if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_CLK_SEL0)
				tick_clock_select <= wr_merged[clock_ctrl_pkg::SEL0_TICK_LSB +: 3];
		end
	end

	// Fail detector control and sticky flag; a new stop wins over a clear
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hs_detect_enable <= 1'b0;
			ls_detect_enable <= 1'b0;
			hs_crystal_fail_irq_enable <= 1'b0;
			hs_crystal_fail_flag <= 1'b0;
			fail_irq_o <= 1'b0;
		end
		else
		begin
			if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_FAIL_CTRL)
			begin
				hs_detect_enable <= wr_merged[clock_ctrl_pkg::FAIL_HS_DET_BIT];
				ls_detect_enable <= wr_merged[clock_ctrl_pkg::FAIL_LS_DET_BIT];
				hs_crystal_fail_irq_enable <= wr_merged[clock_ctrl_pkg::FAIL_HS_IRQ_BIT];
			end
			if (hs_stop)
				hs_crystal_fail_flag <= 1'b1;
			else if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_FAIL_STATUS
				&& wb_dat_i[clock_ctrl_pkg::FAIL_HS_FLAG_BIT] && wb_sel_i[0])
				hs_crystal_fail_flag <= 1'b0;
			fail_irq_o <= hs_crystal_fail_flag & hs_crystal_fail_irq_enable;
		end
	end

	// Clock output and tick control fields
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			output_divider_select <= 4'h0;
			clock_out_enable <= 1'b0;
			divider_bypass <= 1'b0;
			tick_cpu_clock <= 1'b0;
		end
		else
		begin
			if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_CLK_OUT_CTRL)
			begin
				output_divider_select <= wr_merged[clock_ctrl_pkg::CLOCK_OUT_PIN_SEL_LSB +: 4];
				clock_out_enable <= wr_merged[clock_ctrl_pkg::CLOCK_OUT_PIN_EN_BIT];
				divider_bypass <= wr_merged[clock_ctrl_pkg::CLOCK_OUT_PIN_BYPASS_BIT];
			end
			if (wr_fire && wb_adr_i == clock_ctrl_pkg::OFF_TICK_CTRL)
				tick_cpu_clock <= wr_merged[clock_ctrl_pkg::TICK_CPU_BIT];
		end
	end

	// A request is honoured only for a defined, stable source
	assign sel_valid = (system_clock_select <= clock_ctrl_pkg::SRC_RC48) && stable[system_clock_select];

	// Glitch-free switch: let the old clock fall, hold low, join the new one at its low phase
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			switch_state <= clock_ctrl_pkg::SW_IDLE;
			cur_src <= clock_ctrl_pkg::CLK_SEL0_RST[clock_ctrl_pkg::SEL0_SYS_LSB +: 3];
			sys_clk_o <= 1'b0;
		end
		else
		begin
			case (switch_state)
				clock_ctrl_pkg::SW_IDLE:
				begin
					// Gate on the coming state, so the entry edge already drives low
					sys_clk_o <= osc_level[cur_src] & stable[cur_src]
						& (next_power_state == clock_ctrl_pkg::PWR_RUN);
					if (system_clock_select != cur_src && sel_valid)
						switch_state <= clock_ctrl_pkg::SW_DRAIN;
				end
				clock_ctrl_pkg::SW_DRAIN:
				begin
					sys_clk_o <= sys_clk_o & osc_level[cur_src];
					if (!osc_level[cur_src] || !sys_clk_o)
						switch_state <= clock_ctrl_pkg::SW_ARM;
				end
				clock_ctrl_pkg::SW_ARM:
				begin
					sys_clk_o <= 1'b0;
					if (!sel_valid)
						switch_state <= clock_ctrl_pkg::SW_IDLE;
					else if (!osc_level[system_clock_select])
					begin
						cur_src <= system_clock_select;
						switch_state <= clock_ctrl_pkg::SW_IDLE;
					end
				end
				default:
					switch_state <= clock_ctrl_pkg::SW_IDLE;
			endcase
		end
	end

	// Tick clock: CPU clock or one of the external sources
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tick_clk_o <= 1'b0;
		else if (tick_cpu_clock)
			tick_clk_o <= sys_clk_o;
		else if (tick_clock_select <= clock_ctrl_pkg::TICK_SEL_MAX)
			tick_clk_o <= osc_level[tick_clock_select];
		else
			tick_clk_o <= 1'b0;
	end

	// Clock output is fed from the system clock
	clock_out_divider #(
		.STAGES(clock_ctrl_pkg::DIV_STAGES)
	) u_clock_out (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.src_i(sys_clk_o),
		.enable_i(clock_out_enable),
		.bypass_i(divider_bypass),
		.select_i(output_divider_select),
		.clk_out_o(clock_out_pin_o)
	);

endmodule // clock_generation_control

`default_nettype wire

// ### clock_ctrl_checker.sv
// Purpose: Port assertions of the clock controller
// Assumes: One core clock domain
// Notes: Bound below the module
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_checker (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wait_for_interrupt_instr_i,
	input wire logic wakeup_irq_i,
	input wire logic [5:0] osc_enable_o,
	input wire logic sys_clk_o,
	input wire logic powerdown_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers after one cycle, for one cycle
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("no ack");
	property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held");
	// Sleep entry and exit; enable bit is judged by the bench
	property p_pd_entry; $rose(powerdown_o) |-> $past(wait_for_interrupt_instr_i); endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("entry without wait");
	property p_pd_hold; powerdown_o && !wakeup_irq_i |=> powerdown_o; endproperty
	a_pd_hold: assert property (p_pd_hold) else $error("left early");
	property p_pd_wake; powerdown_o && wakeup_irq_i |=> !powerdown_o; endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("no wake");
	property p_pd_fast_off; powerdown_o |-> (osc_enable_o & 6'h35) == 6'h00; endproperty
	a_pd_fast_off: assert property (p_pd_fast_off) else $error("fast source on");
	property p_pd_slow; powerdown_o && $past(powerdown_o) |-> $stable({osc_enable_o[3], osc_enable_o[1]}); endproperty
	a_pd_slow: assert property (p_pd_slow) else $error("slow source moved");
	property p_pd_sys_low; powerdown_o |-> !sys_clk_o; endproperty
	a_pd_sys_low: assert property (p_pd_sys_low) else $error("clock in sleep");
	c_sleep: cover property ($rose(powerdown_o));
	c_wake: cover property ($fell(powerdown_o));
	c_ack: cover property (wb_ack_o);
endmodule // clock_ctrl_checker
bind clock_generation_control clock_ctrl_checker clock_ctrl_checker_inst (.*);
`default_nettype wire

// ### osc_model.sv
// Purpose: Oscillator pins seen by the controller
// Assumes: Every source runs at an eighth of the core clock
// Notes: A stopped or disabled source rests low
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	input wire logic core_clk_i,
	input wire logic [5:0] enable_i,
	input wire logic hs_stop_i,
	output logic [5:0] osc_clk_o
);
	logic [2:0] phase = 3'h0;
	// Free phase; slow enough to avoid aliasing
	always @(posedge core_clk_i) phase <= phase + 3'h1;
	// Unpowered sources give no edges
	assign osc_clk_o = enable_i & {5'h1f, !hs_stop_i} & {6{phase[2]}};
endmodule // osc_model
`default_nettype wire

// ### clock_generation_control_tb_top.sv
// Purpose: Self-checking bench of the clock controller
// Assumes: Sources run at an eighth of the core clock
// Notes: Fail window cut to 16 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module clock_generation_control_tb_top;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, wait_for_interrupt_instr = 1'b0, wake = 1'b0, stop = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, dat;
	logic ack, sys, clock_out_pin, pd, irq, tick;
	logic [5:0] oclk, oen;
	int fails = 0, tests_run = 0, s, o, t;
	clock_generation_control #(.FAIL_WINDOW(16)) clock_generation_control_inst (.core_clk_i(clk), .rst_i(rst),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
		.wb_dat_o(dat), .wb_ack_o(ack), .osc_clk_i(oclk), .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wakeup_irq_i(wake),
		.osc_enable_o(oen), .pll_src_sel_o(), .sys_clk_o(sys), .tick_clk_o(tick), .clock_out_pin_o(clock_out_pin),
		.powerdown_o(pd), .fail_irq_o(irq));
	osc_model osc_model_inst (.core_clk_i(clk), .enable_i(oen), .hs_stop_i(stop), .osc_clk_o(oclk));
	initial forever #12.5 clk = ~clk;
	// One classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk) n++; while (ack !== 1'b1);
		rd = dat;
		cyc <= 1'b0;
		`CHK(n, 2)
	endtask
	// Bounded read loop until masked bits match
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n = 0;
		do
		begin
			bus(1'b0, a, 32'h0);
			n++;
		end
		while ((rd & m) !== v && n < 15000);
		`CHK(rd & m, v)
	endtask
	// Rising edges of system clock and output pin
	task automatic count(input int n);
		s = 0;
		o = 0;
		t = 0;
		fork
			repeat (n) @(posedge clk);
			forever @(posedge sys) s++;
			forever @(posedge clock_out_pin) o++;
			forever @(posedge tick) t++;
		join_any
		disable fork;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		end_sim();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0081_0000)
		bus(1'b0, 8'h20, 32'h0);
		`CHK(rd, 32'h0)
		repeat (1800) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rd[4], 1'b0)
		poll(8'h04, 32'h10, 32'h10);
		bus(1'b1, 8'h00, 32'h0000_200f);
		poll(8'h04, 32'h3f, 32'h3b);
		bus(1'b1, 8'h00, 32'h0000_000f);
		// Flag clears a cycle after the enable output drops
		repeat (2) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rd[5], 1'b0)
		bus(1'b1, 8'h00, 32'h0000_200f);
		// Long enough that a counter left at its target would flag
		repeat (2) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rd[5], 1'b0)
		$display("stable done");
		bus(1'b1, 8'h0c, 32'h0);
		poll(8'h04, 32'h700, 32'h0);
		count(160);
		`CHK(s > 10, 1'b1)
		bus(1'b1, 8'h10, 32'h30);
		bus(1'b1, 8'h00, 32'h0000_200b);
		repeat (2) @(posedge clk);
		`CHK(oen[4], 1'b1)
		stop <= 1'b1;
		poll(8'h04, 32'h700, 32'h400);
		bus(1'b0, 8'h14, 32'h0);
		`CHK({rd[0], irq}, 2'b11)
		stop <= 1'b0;
		repeat (64) @(posedge clk);
		bus(1'b1, 8'h14, 32'h1);
		bus(1'b0, 8'h14, 32'h0);
		`CHK({rd[0], irq}, 2'b00)
		// Keep the fallback RC on by software before the detector lets go
		bus(1'b1, 8'h00, 32'h0000_200f);
		bus(1'b1, 8'h10, 32'h0);
		$display("fail done");
		for (int n = 0; n < 4; n += 2)
		begin
			bus(1'b1, 8'h18, 32'h10 | n);
			count(512);
			`CHK((o - (s >> (n + 1))) inside {[-1:1]}, 1'b1)
		end
		bus(1'b1, 8'h1c, 32'h4);
		bus(1'b1, 8'h18, 32'h30);
		count(256);
		`CHK((o - s) inside {[-1:1]}, 1'b1)
		`CHK((t - s) inside {[-1:1]}, 1'b1)
		bus(1'b1, 8'h18, 32'h13);
		count(100);
		bus(1'b1, 8'h18, 32'h3);
		count(256);
		`CHK({o <= 1, clock_out_pin}, 2'b10)
		$display("clock out done");
		@(posedge clk) wait_for_interrupt_instr <= 1'b1;
		@(posedge clk) wait_for_interrupt_instr <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(pd, 1'b0)
		bus(1'b1, 8'h00, 32'h0000_208f);
		@(posedge clk) wait_for_interrupt_instr <= 1'b1;
		@(posedge clk) wait_for_interrupt_instr <= 1'b0;
		repeat (50) @(posedge clk);
		`CHK({pd, oen}, 7'h4a)
		@(posedge clk) wake <= 1'b1;
		@(posedge clk) wake <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(pd, 1'b0)
		bus(1'b0, 8'h04, 32'h0);
		`CHK(rd[4] | rd[0], 1'b0)
		poll(8'h04, 32'h10, 32'h10);
		$display("sleep done");
		end_sim();
	end
endmodule // clock_generation_control_tb_top
`default_nettype wire
